//--- hw/ncv_pkg.sv
/*
  Constants shared by both ends of the command-selection handshake of a
  fieldbus-to-RS-485 network converter serving two motor drivers.
  Assumes one 50 MHz clock and a synchronous active-low reset everywhere.
*/
package ncv_pkg;

  // ----------------------------------------------------------------------
  // Link layout
  // ----------------------------------------------------------------------
  localparam int unsigned NCV_WORD_W  = 16;
  localparam int unsigned NCV_NUM_CH  = 4;
  localparam int unsigned NCV_NUM_DRV = 2;
  localparam int unsigned NCV_NUM_W   = 16;
  localparam int unsigned NCV_GRP_W   = 4;

  // Word positions inside a four-word group
  localparam logic [1:0] NCV_W_CODE = 2'h0;
  localparam logic [1:0] NCV_W_ADDR = 2'h1;
  localparam logic [1:0] NCV_W_DLO  = 2'h2;
  localparam logic [1:0] NCV_W_DHI  = 2'h3;

  // Channel numbers
  localparam logic [1:0] NCV_CH_WR0  = 2'h0;
  localparam logic [1:0] NCV_CH_WR1  = 2'h1;
  localparam logic [1:0] NCV_CH_MON0 = 2'h2;
  localparam logic [1:0] NCV_CH_MON1 = 2'h3;

  // Commands with special handling
  localparam logic [15:0] NCV_CMD_PRESET    = 16'h30c5;
  localparam logic [31:0] NCV_PRESET_ENABLE = 32'h0000_0001;

  // ----------------------------------------------------------------------
  // Host register map (word addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned NCV_ADDR_W     = 6;
  localparam logic [5:0]  NCV_REG_WBASE  = 6'h00;
  localparam logic [5:0]  NCV_REG_CTRL   = 6'h10;
  localparam logic [5:0]  NCV_REG_STATUS = 6'h11;
  localparam logic [5:0]  NCV_REG_RBASE  = 6'h20;

  // CTRL fields
  localparam int unsigned NCV_CTRL_REQ_LSB = 0;
  localparam int unsigned NCV_CTRL_REV_LSB = 4;

  // ----------------------------------------------------------------------
  // Device channel states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    NCV_ST_IDLE   = 2'b00,
    NCV_ST_QUEUED = 2'b01,
    NCV_ST_BUSY   = 2'b10,
    NCV_ST_DONE   = 2'b11
  } ncv_state_e;

endpackage

//--- hw/ncv_link_if.sv
/*
  Cyclic link between the master station and the converter: sixteen write
  words, four request bits, two reverse-run bits one way; sixteen read
  words and four completion bits the other way.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface ncv_link_if;
  import ncv_pkg::*;

  logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0]  rww;
  logic [NCV_NUM_CH-1:0]                 request;
  logic [NCV_NUM_DRV-1:0]                reverse_continuous_run;
  logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0]  rwr;
  logic [NCV_NUM_CH-1:0]                 complete;

  modport dev (
    input  rww,
    input  request,
    input  reverse_continuous_run,
    output rwr,
    output complete
  );

  modport host (
    output rww,
    output request,
    output reverse_continuous_run,
    input  rwr,
    input  complete
  );
endinterface

//--- hw/ncv_converter.sv
/*
  Converter end of the command-selection handshake. Latches a write group
  when its request rises, hands it to the driver side one at a time,
  echoes the result and raises completion.
  Assumes the driver side answers each DRV_VALID with one DRV_DONE pulse.
*/
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
module ncv_converter
  import ncv_pkg::*;
#(
  parameter int unsigned NUM_CH = NCV_NUM_CH
) (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  ncv_link_if.dev                     LINK,
  output logic                        DRV_VALID,
  output logic [1:0]                  DRV_CHAN,
  output logic                        DRV_MONITOR,
  output logic [NCV_WORD_W-1:0]       DRV_CODE,
  output logic [NCV_WORD_W-1:0]       DRV_ADDR,
  output logic [2*NCV_WORD_W-1:0]     DRV_DATA,
  input  wire logic                   DRV_DONE,
  input  wire logic [2*NCV_WORD_W-1:0] DRV_RESULT,
  output logic [NCV_NUM_DRV-1:0]      REV_RUN
);

  if (NUM_CH != NCV_NUM_CH) begin : g_chk
    $error("ncv_converter: only four channels are supported");
  end

  // ----------------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------------
  ncv_state_e                             state [NCV_NUM_CH];
  logic [NCV_GRP_W-1:0][NCV_WORD_W-1:0]   group [NCV_NUM_CH];
  logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0]   echo;
  logic [NCV_NUM_CH-1:0]                  done_flag;
  logic                                   busy;
  logic [1:0]                             busy_ch;

  // ----------------------------------------------------------------------
  // Arbitration: lowest queued channel first
  // ----------------------------------------------------------------------
  logic [NCV_NUM_CH-1:0] queued;
  logic                  grant_ok;
  logic [1:0]            grant_ch;

  always_comb begin
    queued = '0;
    for (int i = 0; i < NCV_NUM_CH; i++) begin
      queued[i] = (state[i] == NCV_ST_QUEUED);
    end
  end

  assign grant_ok = !busy && (queued != '0);
  assign grant_ch = queued[0] ? 2'h0 :
                    queued[1] ? 2'h1 :
                    queued[2] ? 2'h2 : 2'h3;

  wire [NCV_WORD_W-1:0]   g_code = group[grant_ch][NCV_W_CODE];
  wire [NCV_WORD_W-1:0]   g_addr = group[grant_ch][NCV_W_ADDR];
  wire [2*NCV_WORD_W-1:0] g_data = {group[grant_ch][NCV_W_DHI],
                                    group[grant_ch][NCV_W_DLO]};
  wire                    g_mon  = grant_ch[1];
  // A preset on a write channel without the enable value completes without reaching the
  // driver, so the master still sees its echo and can end the exchange
  wire                    g_skip = !g_mon && (g_code == NCV_CMD_PRESET) &&
                                   (g_data != NCV_PRESET_ENABLE);

  wire                    drv_fin = busy && DRV_DONE;
  wire [2*NCV_WORD_W-1:0] bc_data = {group[busy_ch][NCV_W_DHI],
                                     group[busy_ch][NCV_W_DLO]};
  // Monitor channels return what the driver reported, writes return data
  wire [2*NCV_WORD_W-1:0] fin_data = busy_ch[1] ? DRV_RESULT : bc_data;

  // ----------------------------------------------------------------------
  // Channel state machines
  // ----------------------------------------------------------------------
  ncv_state_e                             next_state [NCV_NUM_CH];
  logic [NCV_GRP_W-1:0][NCV_WORD_W-1:0]   next_group [NCV_NUM_CH];

  // The group is latched on the taking edge, so later changes to the
  // write words cannot tear a command that is already queued
  always_comb begin
    for (int i = 0; i < NCV_NUM_CH; i++) begin
      next_state[i] = state[i];
      next_group[i] = group[i];
      unique case (state[i])
        NCV_ST_IDLE: begin
          if (LINK.request[i]) begin
            next_group[i] = LINK.rww[i*NCV_GRP_W +: NCV_GRP_W];
            next_state[i] = NCV_ST_QUEUED;
          end
        end
        NCV_ST_QUEUED: begin
          if (grant_ok && grant_ch == 2'(i)) begin
            next_state[i] = g_skip ? NCV_ST_DONE : NCV_ST_BUSY;
          end
        end
        NCV_ST_BUSY: begin
          if (drv_fin && busy_ch == 2'(i)) begin
            next_state[i] = NCV_ST_DONE;
          end
        end
        NCV_ST_DONE: begin
          if (!LINK.request[i]) begin
            next_state[i] = NCV_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    for (int i = 0; i < NCV_NUM_CH; i++) begin
      if (!RST_N) begin
        state[i] <= NCV_ST_IDLE;
        group[i] <= '0;
      end else begin
        state[i] <= next_state[i];
        group[i] <= next_group[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Driver hand-off
  // ----------------------------------------------------------------------
  // One command at a time: a second grant waits for DRV_DONE of the
  // first, so the offer fields stay put while DRV_VALID is high
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      busy        <= 1'b0;
      busy_ch     <= 2'h0;
      DRV_VALID   <= 1'b0;
      DRV_CHAN    <= 2'h0;
      DRV_MONITOR <= 1'b0;
      DRV_CODE    <= '0;
      DRV_ADDR    <= '0;
      DRV_DATA    <= '0;
    end else if (drv_fin) begin
      busy      <= 1'b0;
      DRV_VALID <= 1'b0;
    end else if (grant_ok && !g_skip) begin
      busy        <= 1'b1;
      busy_ch     <= grant_ch;
      DRV_VALID   <= 1'b1;
      DRV_CHAN    <= grant_ch;
      DRV_MONITOR <= g_mon;
      DRV_CODE    <= g_code;
      DRV_ADDR    <= g_addr;
      DRV_DATA    <= g_data;
    end
  end

  // ----------------------------------------------------------------------
  // Echo words and completion flags
  // ----------------------------------------------------------------------
  logic [NCV_NUM_CH-1:0]                  echo_fin;
  logic [NCV_NUM_CH-1:0]                  echo_skip;
  logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0]   next_echo;
  logic [NCV_NUM_CH-1:0]                  next_done;

  always_comb begin
    next_echo = echo;
    for (int i = 0; i < NCV_NUM_CH; i++) begin
      echo_fin[i]  = drv_fin && (busy_ch == 2'(i));
      echo_skip[i] = grant_ok && g_skip && (grant_ch == 2'(i));
      // Echo is written one edge before the flag shows, so the master
      // never sees completion beside stale words
      if (echo_fin[i]) begin
        next_echo[i*NCV_GRP_W + NCV_W_CODE] = group[i][NCV_W_CODE];
        next_echo[i*NCV_GRP_W + NCV_W_ADDR] = group[i][NCV_W_ADDR];
        next_echo[i*NCV_GRP_W + NCV_W_DLO]  = fin_data[NCV_WORD_W-1:0];
        next_echo[i*NCV_GRP_W + NCV_W_DHI]  =
          fin_data[2*NCV_WORD_W-1:NCV_WORD_W];
      end else if (echo_skip[i]) begin
        next_echo[i*NCV_GRP_W + NCV_W_CODE] = g_code;
        next_echo[i*NCV_GRP_W + NCV_W_ADDR] = g_addr;
        next_echo[i*NCV_GRP_W + NCV_W_DLO]  = g_data[NCV_WORD_W-1:0];
        next_echo[i*NCV_GRP_W + NCV_W_DHI]  =
          g_data[2*NCV_WORD_W-1:NCV_WORD_W];
      end
      next_done[i] = (state[i] == NCV_ST_DONE) && LINK.request[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      echo      <= '0;
      done_flag <= '0;
    end else begin
      echo      <= next_echo;
      done_flag <= next_done;
    end
  end

  // ----------------------------------------------------------------------
  // Reverse continuous run, straight from the remote outputs
  // ----------------------------------------------------------------------
  // A level with no handshake: one register stage keeps this output on a
  // flip-flop like the others, at the cost of one cycle of lag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REV_RUN <= '0;
    end else begin
      REV_RUN <= LINK.reverse_continuous_run;
    end
  end

  assign LINK.rwr      = echo;
  assign LINK.complete = done_flag;

endmodule

//--- hw/ncv_master.sv
/*
  Master-station end. Software loads write words and control bits through
  a plain register port; the module drives them onto the link and shows
  completion bits and read words back.
  Assumes read data are taken one cycle after the read strobe.
*/
`timescale 1ns/1ps
module ncv_master
  import ncv_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  ncv_link_if.host                    LINK,
  input  wire logic [NCV_ADDR_W-1:0]  ADDR,
  input  wire logic [NCV_WORD_W-1:0]  WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic [NCV_WORD_W-1:0]       RDATA
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0] wword;
  logic [NCV_NUM_CH-1:0]                req;
  logic [NCV_NUM_DRV-1:0]               rev;

  wire       sel_w    = (ADDR[5:4] == NCV_REG_WBASE[5:4]);
  wire       sel_r    = (ADDR[5:4] == NCV_REG_RBASE[5:4]);
  wire       sel_ctrl = (ADDR == NCV_REG_CTRL);
  wire       sel_stat = (ADDR == NCV_REG_STATUS);
  wire [3:0] widx     = ADDR[3:0];

  wire [NCV_WORD_W-1:0] ctrl_val =
    NCV_WORD_W'({rev, req} << NCV_CTRL_REQ_LSB);
  wire [NCV_WORD_W-1:0] rd_mux =
    sel_w    ? wword[widx]        :
    sel_r    ? LINK.rwr[widx]     :
    sel_ctrl ? ctrl_val           :
    sel_stat ? NCV_WORD_W'(LINK.complete) : '0;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wword <= '0;
      req   <= '0;
      rev   <= '0;
      RDATA <= '0;
    end else begin
      if (WR && sel_w) begin
        wword[widx] <= WDATA;
      end
      if (WR && sel_ctrl) begin
        req <= WDATA[NCV_CTRL_REQ_LSB +: NCV_NUM_CH];
        rev <= WDATA[NCV_CTRL_REV_LSB +: NCV_NUM_DRV];
      end
      RDATA <= RD ? rd_mux : '0;
    end
  end

  assign LINK.rww                    = wword;
  assign LINK.request                = req;
  assign LINK.reverse_continuous_run = rev;

endmodule

//--- testbench/ncv_link_properties.sv
/*
  Concurrent checks on the link between the master and converter ends.
  Assumes one shared clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ncv_link_properties
  import ncv_pkg::*;
(
  input wire logic                                 CLK,
  input wire logic                                 RST_N,
  input wire logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0] rww,
  input wire logic [NCV_NUM_CH-1:0]                request,
  input wire logic [NCV_NUM_W-1:0][NCV_WORD_W-1:0] rwr,
  input wire logic [NCV_NUM_CH-1:0]                complete
);
  // ------------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_rise_needs_req: assert property (
    ((complete & ~$past(complete)) & ~request) == '0)
    else $error("completion rose without its request");
  chk_cmp_drop: assert property (
    |(complete & ~request) |-> ##[1:2] ((complete & ~request) == '0))
    else $error("completion stayed after request fell");
  chk_cmp_holds: assert property (
    (~complete & $past(complete) & $past(request)) == '0)
    else $error("completion fell while request was high");
  chk_req_latency: assert property (
    $rose(request[0]) |-> !complete[0] [*3] ##[1:40] complete[0])
    else $error("completion timing off on channel 0");
  // ------------------------------------------------------------------
  // Echo words
  // ------------------------------------------------------------------
  // Write channels echo the whole group, monitor ones code and address
  chk_echo_wr0: assert property (
    $rose(complete[0]) |-> rwr[3:0] == rww[3:0])
    else $error("channel 0 echo differs");
  chk_echo_wr1: assert property (
    $rose(complete[1]) |-> rwr[7:4] == rww[7:4])
    else $error("channel 1 echo differs");
  chk_echo_mon0: assert property (
    $rose(complete[2]) |-> rwr[9:8] == rww[9:8])
    else $error("channel 2 echo differs");
  chk_echo_mon1: assert property (
    $rose(complete[3]) |-> rwr[13:12] == rww[13:12])
    else $error("channel 3 echo differs");
endmodule

//--- testbench/netconv_command_select_handshake_tb.sv
/*
  Testbench joining both ends over the link; plays the driver side.
  Assumes the package and the link interface are compiled first.
*/
`timescale 1ns/1ps
module netconv_command_select_handshake_tb;
  import ncv_pkg::*;

  typedef struct {
    logic [1:0]  ch;
    logic [15:0] code;
    logic [15:0] dlo;
    logic [15:0] dhi;
    logic        sent;
  } ncv_row_s;

  localparam logic [31:0] mon_res = 32'hbeef_0042;

  logic        clk;
  logic        rst_n;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic        drv_valid;
  logic        drv_done;
  logic [1:0]  rev_run;
  logic [1:0]  drv_chan;
  logic        drv_mon;
  logic [15:0] drv_code;
  logic [15:0] drv_addr;
  logic [31:0] drv_data;
  logic [1:0]  sent_chan;
  logic        sent_mon;
  logic [15:0] sent_code;
  logic [15:0] sent_addr;
  logic [31:0] sent_data;
  logic [15:0] num_sent;
  logic [15:0] d;
  logic [15:0] base;
  int          errors;
  int          num_checks;
  ncv_row_s    rows [7];

  ncv_link_if link ();
  ncv_master ncv_master_inst (.CLK(clk), .RST_N(rst_n), .LINK(link),
    .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata));
  ncv_converter ncv_converter_inst (.CLK(clk), .RST_N(rst_n),
    .LINK(link), .DRV_VALID(drv_valid), .DRV_CHAN(drv_chan),
    .DRV_MONITOR(drv_mon), .DRV_CODE(drv_code), .DRV_ADDR(drv_addr),
    .DRV_DATA(drv_data), .DRV_DONE(drv_done),
    .DRV_RESULT(mon_res), .REV_RUN(rev_run));
  ncv_link_properties ncv_link_properties_inst (.CLK(clk), .RST_N(rst_n),
    .rww(link.rww), .request(link.request), .rwr(link.rwr),
    .complete(link.complete));

  // ------------------------------------------------------------------
  // Driver side: answers each offer one cycle later, counts commands
  // and keeps the fields of the last offer taken
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      drv_done <= 1'b0;
      num_sent <= 16'h0;
    end else begin
      drv_done <= drv_valid && !drv_done;
      if (drv_valid && drv_done) begin
        num_sent  <= num_sent + 16'h1;
        sent_chan <= drv_chan;
        sent_mon  <= drv_mon;
        sent_code <= drv_code;
        sent_addr <= drv_addr;
        sent_data <= drv_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input string what, input logic [5:0] a,
                        input logic [15:0] exp);
    rd(a);
    cmp(what, exp, d);
  endtask

  task automatic wait_status(input logic [3:0] mask, input logic [3:0] want);
    int n;
    n = 0;
    rd(NCV_REG_STATUS);
    while ((d[3:0] & mask) !== want) begin
      n++;
      if (n > 60) begin
        errors++;
        finish_test();
      end
      rd(NCV_REG_STATUS);
    end
  endtask

  task automatic run_row(input ncv_row_s r);
    logic [5:0]  g;
    logic [15:0] a;
    g = {2'h0, r.ch, 2'h0};
    a = {15'h0, r.ch[0]};
    base = num_sent;
    wr(g, r.code);
    wr(g + 6'h1, a);
    wr(g + 6'h2, r.dlo);
    wr(g + 6'h3, r.dhi);
    wr(NCV_REG_CTRL, 16'h1 << r.ch);
    wait_status(4'h1 << r.ch, 4'h1 << r.ch);
    chk_rd("echo code", NCV_REG_RBASE | g, r.code);
    chk_rd("echo addr", NCV_REG_RBASE | g | 6'h1, a);
    chk_rd("echo dlo", NCV_REG_RBASE | g | 6'h2,
           r.ch[1] ? mon_res[15:0] : r.dlo);
    chk_rd("echo dhi", NCV_REG_RBASE | g | 6'h3,
           r.ch[1] ? mon_res[31:16] : r.dhi);
    cmp("driver commands", base + {15'h0, r.sent}, num_sent);
    if (r.sent) begin
      cmp("offer channel", {14'h0, r.ch}, {14'h0, sent_chan});
      cmp("offer monitor", {15'h0, r.ch[1]}, {15'h0, sent_mon});
      cmp("offer code", r.code, sent_code);
      cmp("offer addr", a, sent_addr);
      cmp("offer dlo", r.dlo, sent_data[15:0]);
      cmp("offer dhi", r.dhi, sent_data[31:16]);
    end
    wr(NCV_REG_CTRL, 16'h0);
    wait_status(4'h1 << r.ch, 4'h0);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    addr = 6'h0;
    wdata = 16'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    errors = 0;
    num_checks = 0;
    // Preset runs only with data exactly 1; monitor echoes the result
    rows = '{'{2'h0, 16'h30c5, 16'h0001, 16'h0000, 1'b1},
             '{2'h1, 16'h30c5, 16'h0001, 16'h0000, 1'b1},
             '{2'h0, 16'h1200, 16'h1388, 16'h0000, 1'b1},
             '{2'h1, 16'h30c5, 16'h0002, 16'h0000, 1'b0},
             '{2'h0, 16'h30c5, 16'h0001, 16'h0001, 1'b0},
             '{2'h2, 16'h2066, 16'h0000, 16'h0000, 1'b1},
             '{2'h3, 16'h2066, 16'h0000, 16'h0000, 1'b1}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
      run_row(rows[i]);
    // Both write channels at once: served one after the other
    base = num_sent;
    wr(6'h00, 16'h1200);
    wr(6'h04, 16'h1200);
    wr(NCV_REG_CTRL, 16'h3);
    wait_status(4'h3, 4'h3);
    cmp("driver commands", base + 16'h2, num_sent);
    cmp("offer channel", 16'h1, {14'h0, sent_chan});
    wr(NCV_REG_CTRL, 16'h0);
    wait_status(4'h3, 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(NCV_REG_CTRL, {10'h0, 2'(i + 1), 4'h0});
      @(posedge clk);
      #1 cmp("reverse run", {14'h0, 2'(i + 1)}, {14'h0, rev_run});
    end
    chk_rd("unmapped", 6'h3f, 16'h0);
    // Reset in the middle of a channel 0 exchange with both runs on
    wr(NCV_REG_CTRL, 16'h0031);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("status after reset", NCV_REG_STATUS, 16'h0);
    chk_rd("echo after reset", NCV_REG_RBASE, 16'h0);
    chk_rd("control after reset", NCV_REG_CTRL, 16'h0);
    cmp("reverse after reset", 16'h0, {14'h0, rev_run});
    finish_test();
  end
endmodule
